//--- logic/slave_ctrl_defines.svh
// Constants for the slave controller execution unit.
`ifndef SLAVE_CTRL_DEFINES_SVH
`define SLAVE_CTRL_DEFINES_SVH
`define BANK1_BASE 6'h18
`define STACK_BASE 6'h08
`define PAGE3_BITS 3'b011
`define ST_OBF_BIT 0
`define ST_IBF_BIT 1
`define ST_F0_BIT 2
`define ST_F1_BIT 3
`define ACC_RESET 8'h00
`define PC_RESET 12'h000
`define PORT_RESET 8'hFF
`define EXP_RESET 16'h0000
`define TC_PRESCALE 32
`define TC_COUNT_RESET 8'h00
`define DATA_ONE 8'h01
`endif

//--- logic/slave_ctrl_pkg.sv
// Types shared by the slave controller execution unit and its timer.
package slave_ctrl_pkg;
  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_EXT_IRQ_ALLOW = 6'h01, OP_EXT_IRQ_BLOCK = 6'h02,
    OP_TIMER_IRQ_ALLOW = 6'h03, OP_TIMER_IRQ_BLOCK = 6'h04, OP_BANK_SEL = 6'h05,
    OP_MOV_A_IMM = 6'h06, OP_MOV_A_REG = 6'h07, OP_MOV_A_IND = 6'h08,
    OP_MOV_REG_IMM = 6'h09, OP_MOV_REG_A = 6'h0A, OP_MOV_IND_A = 6'h0B,
    OP_MOV_IND_IMM = 6'h0C, OP_MOV_A_PSW = 6'h0D, OP_MOV_PSW_A = 6'h0E,
    OP_INPAGE_LOOKUP = 6'h0F, OP_PAGE3_LOOKUP = 6'h10, OP_DIGIT_XCH = 6'h11,
    OP_FLAG_CLR = 6'h12, OP_FLAG_CPL = 6'h13, OP_STATUS_WR = 6'h14,
    OP_PORT_AND = 6'h15, OP_PORT_OR = 6'h16, OP_PORT_IN = 6'h17,
    OP_PORT_OUT = 6'h18, OP_HOST_IN = 6'h19, OP_HOST_OUT = 6'h1A,
    OP_EXP_IN = 6'h1B, OP_EXP_OUT = 6'h1C, OP_EXP_AND = 6'h1D,
    OP_EXP_OR = 6'h1E, OP_DEC_REG = 6'h1F, OP_INC_REG = 6'h20,
    OP_INC_IND = 6'h21, OP_CALL = 6'h22, OP_RET = 6'h23,
    OP_RETURN_RESTORE_STATUS = 6'h24, OP_MOV_A_T = 6'h25, OP_MOV_T_A = 6'h26,
    OP_CNT_BEGIN = 6'h27, OP_TIMER_BEGIN = 6'h28, OP_TC_HALT = 6'h29
  } op_type;
  typedef enum logic {ST_EXEC = 1'b0, ST_SECOND = 1'b1} exec_state_type;
  typedef enum logic [1:0] {
    TC_IDLE = 2'b00, TC_TIMER = 2'b01, TC_EVENT = 2'b10
  } tc_mode_type;
endpackage : slave_ctrl_pkg

//--- logic/timer_counter.sv
// Eight-bit timer/counter run from a prescaled clock or from input events.
`timescale 1ns/1ps
`include "slave_ctrl_defines.svh"
module timer_counter #(
  parameter int PRESCALE = `TC_PRESCALE
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Commands, one-cycle pulses
  input wire logic timer_begin_i,
  input wire logic event_begin_i,
  input wire logic halt_i,
  input wire logic load_i,
  input wire logic [7:0] load_data_i,
  // Synchronised event input level
  input wire logic event_lvl_i,
  // Results
  output logic [7:0] count_o,
  output logic overflow_o
);
  import slave_ctrl_pkg::*;
  localparam int PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
  tc_mode_type mode, next_mode;
  logic [PW-1:0] pre, next_pre;
  logic [7:0] next_count;
  logic evt_prev, next_overflow, tick;

  always_comb
  begin
    next_mode = mode;
    next_pre = pre;
    next_count = count_o;
    tick = 1'b0;
    unique case (mode)
      TC_TIMER:
      begin
        next_pre = (pre == PRE_LAST) ? '0 : pre + 1'b1;
        tick = (pre == PRE_LAST);
      end
      TC_EVENT: tick = evt_prev & ~event_lvl_i;
      TC_IDLE: tick = 1'b0;
      default: next_mode = TC_IDLE;
    endcase
    if (tick)
      next_count = count_o + `DATA_ONE;
    next_overflow = tick && (count_o == 8'hFF);
    if (load_i)
      next_count = load_data_i;
    if (timer_begin_i)
    begin
      next_mode = TC_TIMER;
      next_pre = '0;
    end
    if (event_begin_i)
      next_mode = TC_EVENT;
    if (halt_i)
      next_mode = TC_IDLE;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode <= TC_IDLE;
      pre <= '0;
      count_o <= `TC_COUNT_RESET;
      // The event pin idles high, so a low start would look like a rising edge.
      evt_prev <= 1'b1;
      overflow_o <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      pre <= next_pre;
      count_o <= next_count;
      evt_prev <= event_lvl_i;
      overflow_o <= next_overflow;
    end
  end

  property p_halt_holds;
    @(posedge clk_i) disable iff (!rst_n_i)
    (halt_i && !load_i) |=> (mode == TC_IDLE) ##1 $stable(count_o) || $past(load_i);
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("Halted count moved");
endmodule : timer_counter

//--- logic/slave_exec_unit.sv
// Execution unit of the slave peripheral controller for control, move and I/O instructions.
// Notes on behaviour
// - Page-three lookup: PC low from A, PC 8-10 forced 011, byte to A, two cycles.
// - In-page lookup replaces PC low byte with A and loads that byte into A.
// - Status write copies A bits 4-7 to status bits 4-7, lower bits kept.
// - Expander read of ports 4-7 puts nibble in A low, clears A high.
// - Expander write sends A low nibble to port 4-7, one cycle, one byte.
// - Port AND/OR immediate on ports 1-2 write back result, two cycles.
// - Expander AND/OR combine selected nibble port with A low and store it.
// - Port 1-2 read takes two cycles, latched write one, full byte.
// - Call pushes PC and PSW bits 4-7, bumps SP, PC 11 from bank flip-flop.
// - Digit exchange swaps A low nibble with RAM low nibble via R0/R1.
// - Indirect pointers are R0 or R1 only; direct operands use R0-R7.
// - Immediate indirect store writes second byte via R0/R1, two cycles.
// - Register increment/decrement wrap modulo 256; increment also indirect.
// - Register immediate load writes second byte to register, two cycles.
// - Event-counter start makes the counter count external events.
// - Timer start makes the counter run from the internal time base.
// - Stop halts timer or counter and holds its value.
// - Separate instructions allow and block external interrupt; blocked never vectors.
`timescale 1ns/1ps
`include "slave_ctrl_defines.svh"
module slave_exec_unit #(
  parameter int TC_PRESCALE = `TC_PRESCALE
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  // Decoded instruction
  input wire logic CMD_VALID_I,
  input wire slave_ctrl_pkg::op_type CMD_OP_I,
  input wire logic [2:0] CMD_SEL_I,
  input wire logic [7:0] CMD_DATA_I,
  input wire logic [2:0] CMD_PAGE_I,
  input wire logic MEM_BANK_I,
  output logic CMD_READY_O,
  // Program memory
  output logic [11:0] PMEM_ADDR_O,
  input wire logic [7:0] PMEM_DATA_I,
  // Ports 1 and 2
  input wire logic [7:0] P1_I,
  input wire logic [7:0] P2_I,
  output logic [7:0] P1_O,
  output logic [7:0] P2_O,
  // Expander ports 4 to 7, one nibble each
  input wire logic [15:0] EXP_IN_I,
  output logic [15:0] EXP_OUT_O,
  // Host data buffer
  input wire logic [7:0] HOST_DATA_I,
  input wire logic HOST_WR_I,
  input wire logic HOST_RD_I,
  output logic [7:0] HOST_DATA_O,
  output logic [7:0] STATUS_O,
  // Timer, interrupts and state
  input wire logic T1_I,
  input wire logic EXT_IRQ_N_I,
  input wire logic TIMER_IRQ_ACK_I,
  output logic EXT_IRQ_REQ_O,
  output logic TIMER_IRQ_REQ_O,
  output logic [7:0] ACC_O,
  output logic [7:0] PSW_O
);
  import slave_ctrl_pkg::*;

  function automatic logic [5:0] reg_addr(input logic bank, input logic [2:0] r);
    reg_addr = bank ? 6'(`BANK1_BASE + {3'b000, r}) : {3'b000, r};
  endfunction : reg_addr

  exec_state_type state, next_state;
  logic [7:0] ram [64];
  logic [7:0] next_acc, p1_s1, p2_s1, p1_s2, p2_s2, next_p1, next_p2;
  logic [7:0] host_in, next_host_in, next_host_out;
  logic [15:0] exp_s1, exp_s2, next_exp;
  logic [11:0] pc, next_pc;
  logic [2:0] sp, next_sp;
  logic [3:0] user_status, next_user_status, exp_nib, exp_pin;
  logic c, ac, f0, f1, bs, next_c, next_ac, next_f0, next_f1, next_bs;
  logic input_full_flag, output_full_flag, next_ibf, next_obf, ext_en, tmr_en, next_ext_en, next_tmr_en;
  logic tof, next_tof, lookup, next_lookup, take;
  logic t1_s1, t1_s2, irq_s1, irq_s2;
  logic we0, we1, tc_tbeg, tc_ebeg, tc_halt, tc_load, tc_ovf;
  logic [5:0] wa0, wa1, raddr, iaddr, push_addr, pop_addr;
  logic [7:0] wd0, wd1, reg_val, ind_val, port_val, tc_count;
  logic [7:0] pop_lo, pop_hi;

  assign take = CMD_VALID_I && (state == ST_EXEC);
  assign CMD_READY_O = (state == ST_EXEC);
  assign raddr = reg_addr(bs, CMD_SEL_I);
  assign iaddr = ram[reg_addr(bs, {2'b00, CMD_SEL_I[0]})][5:0];
  assign reg_val = ram[raddr];
  assign ind_val = ram[iaddr];
  assign push_addr = 6'(`STACK_BASE + {2'b00, sp, 1'b0});
  assign pop_addr = 6'(`STACK_BASE + {2'b00, 3'(sp - 3'd1), 1'b0});
  assign pop_lo = ram[pop_addr];
  assign pop_hi = ram[6'(pop_addr + 6'd1)];
  assign port_val = CMD_SEL_I[0] ? P2_O : P1_O;
  assign exp_nib = EXP_OUT_O[{CMD_SEL_I[1:0], 2'b00} +: 4];
  assign exp_pin = exp_s2[{CMD_SEL_I[1:0], 2'b00} +: 4];
  assign PMEM_ADDR_O = pc;
  assign PSW_O = {c, ac, f0, bs, 1'b1, sp};
  assign STATUS_O = {user_status, f1, f0, input_full_flag, output_full_flag};
  assign EXT_IRQ_REQ_O = ext_en & ~irq_s2;
  assign TIMER_IRQ_REQ_O = tmr_en & tof;

  always_comb
  begin
    next_state = state;
    next_acc = ACC_O;
    next_pc = pc;
    next_sp = sp;
    {next_c, next_ac, next_f0, next_f1, next_bs} = {c, ac, f0, f1, bs};
    next_user_status = user_status;
    next_p1 = P1_O;
    next_p2 = P2_O;
    next_exp = EXP_OUT_O;
    next_host_in = host_in;
    next_host_out = HOST_DATA_O;
    next_ibf = input_full_flag;
    next_obf = output_full_flag & ~HOST_RD_I;
    next_ext_en = ext_en;
    next_tmr_en = tmr_en;
    next_tof = tof & ~TIMER_IRQ_ACK_I;
    next_lookup = 1'b0;
    {we0, we1, wa0, wa1, wd0, wd1} = '0;
    {tc_tbeg, tc_ebeg, tc_halt, tc_load} = 4'b0000;
    if (state == ST_SECOND)
    begin
      next_state = ST_EXEC;
      if (lookup)
        next_acc = PMEM_DATA_I;
    end
    else if (take)
    begin
      unique case (CMD_OP_I)
        OP_PAGE3_LOOKUP, OP_INPAGE_LOOKUP, OP_PORT_AND, OP_PORT_OR, OP_PORT_IN,
        OP_EXP_IN, OP_EXP_AND, OP_CALL, OP_RET, OP_RETURN_RESTORE_STATUS, OP_MOV_REG_IMM,
        OP_MOV_IND_IMM, OP_MOV_A_IMM: next_state = ST_SECOND;
        default: next_state = ST_EXEC;
      endcase
      unique case (CMD_OP_I)
        OP_NOP: next_state = ST_EXEC;
        OP_EXT_IRQ_ALLOW: next_ext_en = 1'b1;
        OP_EXT_IRQ_BLOCK: next_ext_en = 1'b0;
        OP_TIMER_IRQ_ALLOW: next_tmr_en = 1'b1;
        OP_TIMER_IRQ_BLOCK: next_tmr_en = 1'b0;
        OP_BANK_SEL: next_bs = CMD_SEL_I[0];
        OP_MOV_A_IMM: next_acc = CMD_DATA_I;
        OP_MOV_A_REG: next_acc = reg_val;
        OP_MOV_A_IND: next_acc = ind_val;
        OP_MOV_REG_IMM: {we0, wa0, wd0} = {1'b1, raddr, CMD_DATA_I};
        OP_MOV_REG_A: {we0, wa0, wd0} = {1'b1, raddr, ACC_O};
        OP_MOV_IND_A: {we0, wa0, wd0} = {1'b1, iaddr, ACC_O};
        OP_MOV_IND_IMM: {we0, wa0, wd0} = {1'b1, iaddr, CMD_DATA_I};
        OP_MOV_A_PSW: next_acc = PSW_O;
        OP_MOV_PSW_A: {next_c, next_ac, next_f0, next_bs, next_sp} =
          {ACC_O[7:4], ACC_O[2:0]};
        OP_INPAGE_LOOKUP:
        begin
          next_pc = {pc[11:8], ACC_O};
          next_lookup = 1'b1;
        end
        OP_PAGE3_LOOKUP:
        begin
          next_pc = {pc[11], `PAGE3_BITS, ACC_O};
          next_lookup = 1'b1;
        end
        OP_DIGIT_XCH:
        begin
          next_acc = {ACC_O[7:4], ind_val[3:0]};
          {we0, wa0, wd0} = {1'b1, iaddr, ind_val[7:4], ACC_O[3:0]};
        end
        OP_FLAG_CLR, OP_FLAG_CPL:
        begin
          // Selector 0 is the carry, 1 is the first user flag, 2 the second.
          if (CMD_SEL_I == 3'd0)
            next_c = (CMD_OP_I == OP_FLAG_CPL) & ~c;
          if (CMD_SEL_I == 3'd1)
            next_f0 = (CMD_OP_I == OP_FLAG_CPL) & ~f0;
          if (CMD_SEL_I == 3'd2)
            next_f1 = (CMD_OP_I == OP_FLAG_CPL) & ~f1;
        end
        OP_STATUS_WR: next_user_status = ACC_O[7:4];
        OP_PORT_AND, OP_PORT_OR, OP_PORT_OUT:
        begin
          if (CMD_OP_I == OP_PORT_OUT)
            wd1 = ACC_O;
          else if (CMD_OP_I == OP_PORT_AND)
            wd1 = port_val & CMD_DATA_I;
          else
            wd1 = port_val | CMD_DATA_I;
          if (CMD_SEL_I[0])
            next_p2 = wd1;
          else
            next_p1 = wd1;
        end
        OP_PORT_IN: next_acc = CMD_SEL_I[0] ? p2_s2 : p1_s2;
        OP_HOST_IN:
        begin
          next_acc = host_in;
          next_ibf = 1'b0;
        end
        OP_HOST_OUT:
        begin
          next_host_out = ACC_O;
          next_obf = 1'b1;
        end
        OP_EXP_IN: next_acc = {4'h0, exp_pin};
        OP_EXP_OUT: next_exp[{CMD_SEL_I[1:0], 2'b00} +: 4] = ACC_O[3:0];
        OP_EXP_AND: next_exp[{CMD_SEL_I[1:0], 2'b00} +: 4] = exp_nib & ACC_O[3:0];
        OP_EXP_OR: next_exp[{CMD_SEL_I[1:0], 2'b00} +: 4] = exp_nib | ACC_O[3:0];
        OP_DEC_REG: {we0, wa0, wd0} = {1'b1, raddr, 8'(reg_val - `DATA_ONE)};
        OP_INC_REG: {we0, wa0, wd0} = {1'b1, raddr, 8'(reg_val + `DATA_ONE)};
        OP_INC_IND: {we0, wa0, wd0} = {1'b1, iaddr, 8'(ind_val + `DATA_ONE)};
        OP_CALL:
        begin
          {we0, wa0, wd0} = {1'b1, push_addr, pc[7:0]};
          {we1, wa1, wd1} = {1'b1, 6'(push_addr + 6'd1), c, ac, f0, bs, pc[11:8]};
          next_sp = 3'(sp + 3'd1);
          next_pc = {MEM_BANK_I, CMD_PAGE_I, CMD_DATA_I};
        end
        OP_RET, OP_RETURN_RESTORE_STATUS:
        begin
          next_sp = 3'(sp - 3'd1);
          next_pc = {pop_hi[3:0], pop_lo};
          if (CMD_OP_I == OP_RETURN_RESTORE_STATUS)
            {next_c, next_ac, next_f0, next_bs} = pop_hi[7:4];
        end
        OP_MOV_A_T: next_acc = tc_count;
        OP_MOV_T_A: tc_load = 1'b1;
        OP_CNT_BEGIN: tc_ebeg = 1'b1;
        OP_TIMER_BEGIN: tc_tbeg = 1'b1;
        OP_TC_HALT: tc_halt = 1'b1;
      endcase
    end
    // A host write in the same cycle as a buffer read keeps the flag set.
    if (HOST_WR_I)
    begin
      next_ibf = 1'b1;
      next_host_in = HOST_DATA_I;
    end
    if (tc_ovf)
      next_tof = 1'b1;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (we0)
      ram[wa0] <= wd0;
    if (we1)
      ram[wa1] <= wd1;
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      state <= ST_EXEC;
      ACC_O <= `ACC_RESET;
      pc <= `PC_RESET;
      sp <= 3'b000;
      {c, ac, f0, f1, bs} <= 5'b00000;
      user_status <= 4'h0;
      P1_O <= `PORT_RESET;
      P2_O <= `PORT_RESET;
      EXP_OUT_O <= `EXP_RESET;
      host_in <= 8'h00;
      HOST_DATA_O <= 8'h00;
      {input_full_flag, output_full_flag, ext_en, tmr_en, tof, lookup} <= 6'b000000;
      {p1_s1, p2_s1, p1_s2, p2_s2} <= 32'h0000_0000;
      {exp_s1, exp_s2} <= 32'h0000_0000;
      // Both pins idle high; starting there keeps reset from looking like an edge.
      {t1_s1, t1_s2, irq_s1, irq_s2} <= 4'b1111;
    end
    else
    begin
      state <= next_state;
      ACC_O <= next_acc;
      pc <= next_pc;
      sp <= next_sp;
      {c, ac, f0, f1, bs} <= {next_c, next_ac, next_f0, next_f1, next_bs};
      user_status <= next_user_status;
      P1_O <= next_p1;
      P2_O <= next_p2;
      EXP_OUT_O <= next_exp;
      host_in <= next_host_in;
      HOST_DATA_O <= next_host_out;
      {input_full_flag, output_full_flag, ext_en, tmr_en, tof, lookup} <=
        {next_ibf, next_obf, next_ext_en, next_tmr_en, next_tof, next_lookup};
      {p1_s1, p2_s1, p1_s2, p2_s2} <= {P1_I, P2_I, p1_s1, p2_s1};
      {exp_s1, exp_s2} <= {EXP_IN_I, exp_s1};
      {t1_s1, t1_s2, irq_s1, irq_s2} <= {T1_I, t1_s1, EXT_IRQ_N_I, irq_s1};
    end
  end

  timer_counter #(
    .PRESCALE(TC_PRESCALE)
  ) u_timer (
    .clk_i(MCLK_I),
    .rst_n_i(ARST_N_I),
    .timer_begin_i(tc_tbeg),
    .event_begin_i(tc_ebeg),
    .halt_i(tc_halt),
    .load_i(tc_load),
    .load_data_i(ACC_O),
    .event_lvl_i(t1_s2),
    .count_o(tc_count),
    .overflow_o(tc_ovf)
  );

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_lookup_addr;
    (pc[10:8] == `PAGE3_BITS) && (pc[7:0] == $past(ACC_O)) && !CMD_READY_O;
  endsequence
  sequence s_lookup_load;
    ACC_O == $past(PMEM_DATA_I);
  endsequence
  property p_page3;
    (take && CMD_OP_I == OP_PAGE3_LOOKUP) |=> s_lookup_addr ##1 s_lookup_load;
  endproperty
  a_page3: assert property (p_page3) else $error("Page-three lookup wrong");
  property p_inpage;
    (take && CMD_OP_I == OP_INPAGE_LOOKUP) |=> (pc[7:0] == $past(ACC_O))
      && (pc[11:8] == $past(pc[11:8])) ##1 s_lookup_load;
  endproperty
  a_inpage: assert property (p_inpage) else $error("In-page lookup wrong");
  property p_status;
    (take && CMD_OP_I == OP_STATUS_WR) |=> STATUS_O[7:4] == $past(ACC_O[7:4]);
  endproperty
  a_status: assert property (p_status) else $error("Status nibble not copied");
  property p_exp_in;
    (take && CMD_OP_I == OP_EXP_IN) |=> ACC_O == {4'h0, $past(exp_pin)};
  endproperty
  a_exp_in: assert property (p_exp_in) else $error("Expander read wrong");
  property p_port_out;
    (take && CMD_OP_I == OP_PORT_OUT && !CMD_SEL_I[0]) |=> P1_O == $past(ACC_O) && CMD_READY_O;
  endproperty
  a_port_out: assert property (p_port_out) else $error("Port write wrong");
  property p_dec;
    (take && CMD_OP_I == OP_DEC_REG) |=> ram[$past(raddr)] == 8'($past(reg_val) - 8'h01);
  endproperty
  a_dec: assert property (p_dec) else $error("Register decrement wrong");
  property p_call;
    (take && CMD_OP_I == OP_CALL) |=> sp == 3'($past(sp) + 3'd1)
      && pc == {$past(MEM_BANK_I), $past(CMD_PAGE_I), $past(CMD_DATA_I)} ##1 CMD_READY_O;
  endproperty
  a_call: assert property (p_call) else $error("Call wrong");
  property p_ret;
    (take && (CMD_OP_I == OP_RET || CMD_OP_I == OP_RETURN_RESTORE_STATUS)) |=> sp == 3'($past(sp) - 3'd1);
  endproperty
  a_ret: assert property (p_ret) else $error("Return stack pointer wrong");
  property p_block;
    (take && CMD_OP_I == OP_EXT_IRQ_BLOCK) |=> !EXT_IRQ_REQ_O;
  endproperty
  a_block: assert property (p_block) else $error("Blocked interrupt requested");
  property p_host_in;
    (take && CMD_OP_I == OP_HOST_IN && !HOST_WR_I) |=> !input_full_flag && ACC_O == $past(host_in);
  endproperty
  a_host_in: assert property (p_host_in) else $error("Buffer read wrong");
endmodule : slave_exec_unit

//--- test/pmem_model.sv
// Program memory model that answers the execution unit's fetch address.
`timescale 1ns/1ps
module pmem_model (
  // Fetch address
  input wire logic [11:0] addr_i,
  // Read data
  output logic [7:0] data_o
);
  // Mixing the upper address bits in makes a wrong page visible in the data.
  assign data_o = addr_i[7:0] ^ {addr_i[11:8], addr_i[11:8]};
endmodule : pmem_model

//--- test/test_slave_exec_unit.sv
// Self-checking testbench for the slave controller execution unit.
`timescale 1ns/1ps
module test_slave_exec_unit;
  import slave_ctrl_pkg::*;
  localparam int PRE = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic vld = 1'b0, bank = 1'b0, hwr = 1'b0, hrd = 1'b0, t1 = 1'b1, irq_n = 1'b1, ack = 1'b0;
  op_type cop = OP_NOP;
  logic [2:0] sel = 3'h0, page = 3'h0;
  logic [7:0] dat = 8'h00, p1i = 8'h00, p2i = 8'h00, hdi = 8'h00, pd, acc, p1o, p2o, hdo, st, program_status_word;
  logic [15:0] expi = 16'h0000, expo, em;
  logic [11:0] pa;
  logic rdy, ereq, treq, rng;
  logic [7:0] v, k, m;
  logic [15:0] exp_q[$];
  int sel_q[$];
  int error_cnt = 0, total_checks = 0, cyc = 0;
  int seed = 32'hd4d3_f545;
  event result_ev;
  string names[12] = '{"acc", "p1", "p2", "exp", "status", "psw", "host_out", "pc",
                       "ext_req", "tmr_req", "ready", "tmr_range"};
  always #50 clk = ~clk;
  slave_exec_unit #(.TC_PRESCALE(PRE)) u_dut (.MCLK_I(clk), .ARST_N_I(arst_n),
    .CMD_VALID_I(vld), .CMD_OP_I(cop), .CMD_SEL_I(sel), .CMD_DATA_I(dat), .CMD_PAGE_I(page),
    .MEM_BANK_I(bank), .CMD_READY_O(rdy), .PMEM_ADDR_O(pa), .PMEM_DATA_I(pd), .P1_I(p1i),
    .P2_I(p2i), .P1_O(p1o), .P2_O(p2o), .EXP_IN_I(expi), .EXP_OUT_O(expo), .HOST_DATA_I(hdi),
    .HOST_WR_I(hwr), .HOST_RD_I(hrd), .HOST_DATA_O(hdo), .STATUS_O(st), .T1_I(t1),
    .EXT_IRQ_N_I(irq_n), .TIMER_IRQ_ACK_I(ack), .EXT_IRQ_REQ_O(ereq),
    .TIMER_IRQ_REQ_O(treq), .ACC_O(acc), .PSW_O(program_status_word));
  pmem_model u_pmem (.addr_i(pa), .data_o(pd));
  function automatic logic [15:0] probe(input int s);
    case (s)
      0: return {8'h00, acc};
      1: return {8'h00, p1o};
      2: return {8'h00, p2o};
      3: return expo;
      4: return {8'h00, st};
      5: return {8'h00, program_status_word};
      6: return {8'h00, hdo};
      7: return {4'h0, pa};
      8: return {15'h0000, ereq};
      9: return {15'h0000, treq};
      10: return {15'h0000, rdy};
      default: return {15'h0000, rng};
    endcase
  endfunction : probe
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task note(input int s, input logic [15:0] e);
    sel_q.push_back(s);
    exp_q.push_back(e);
    ->result_ev;
  endtask : note
  // The watcher drains every pending note against the settled outputs.
  always @(result_ev)
  begin
    while (sel_q.size() > 0)
    begin
      automatic int s = sel_q.pop_front();
      check(names[s], probe(s), exp_q.pop_front());
    end
  end
  // Holds the request until an edge sees ready high, then waits for two-cycle results.
  task exec(input op_type o, input logic [2:0] s, input logic [7:0] d);
    int n;
    @(negedge clk);
    vld = 1'b1;
    cop = o;
    sel = s;
    dat = d;
    n = 0;
    while (rdy !== 1'b1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    vld = 1'b0;
    repeat (2) @(negedge clk);
  endtask : exec
  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  initial
  begin
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    note(0, 16'h0000);
    note(1, 16'h00ff);
    note(4, 16'h0000);
    note(5, 16'h0008);
    note(10, 16'h0001);
    // Host buffer handshake; flags settle one cycle after the strobe.
    hdi = $random(seed);
    hwr = 1'b1;
    idle(1);
    hwr = 1'b0;
    idle(1);
    note(4, 16'h0002);
    exec(OP_HOST_IN, 3'h0, 8'h00);
    note(0, {8'h00, hdi});
    note(4, 16'h0000);
    exec(OP_MOV_A_IMM, 3'h0, 8'h6b);
    exec(OP_HOST_OUT, 3'h0, 8'h00);
    note(6, 16'h006b);
    note(4, 16'h0001);
    hrd = 1'b1;
    idle(1);
    hrd = 1'b0;
    idle(1);
    note(4, 16'h0000);
    // Status nibble write keeps the flag bits below it.
    exec(OP_FLAG_CPL, 3'h1, 8'h00);
    exec(OP_MOV_A_IMM, 3'h0, 8'ha5);
    exec(OP_STATUS_WR, 3'h0, 8'h00);
    note(4, 16'h00a4);
    // Ports 1 and 2: latched write, immediate AND/OR on the latch, pin read.
    p1i = $random(seed);
    p2i = $random(seed);
    for (int s = 0; s < 2; s++)
    begin
      v = $random(seed);
      k = $random(seed);
      m = $random(seed);
      exec(OP_MOV_A_IMM, 3'h0, v);
      exec(OP_PORT_OUT, s[2:0], 8'h00);
      note(1 + s, {8'h00, v});
      exec(OP_PORT_AND, s[2:0], k);
      note(1 + s, {8'h00, v & k});
      exec(OP_PORT_OR, s[2:0], m);
      note(1 + s, {8'h00, (v & k) | m});
      exec(OP_PORT_IN, s[2:0], 8'h00);
      note(0, {8'h00, s == 0 ? p1i : p2i});
    end
    // Expander ports 4 to 7, one nibble each.
    expi = $random(seed);
    em = 16'h0000;
    for (int p = 0; p < 4; p++)
    begin
      v = $random(seed);
      k = $random(seed);
      m = $random(seed);
      exec(OP_MOV_A_IMM, 3'h0, v);
      exec(OP_EXP_OUT, p[2:0], 8'h00);
      em[p*4+:4] = v[3:0];
      note(3, em);
      exec(OP_MOV_A_IMM, 3'h0, k);
      exec(OP_EXP_AND, p[2:0], 8'h00);
      em[p*4+:4] = em[p*4+:4] & k[3:0];
      note(3, em);
      exec(OP_MOV_A_IMM, 3'h0, m);
      exec(OP_EXP_OR, p[2:0], 8'h00);
      em[p*4+:4] = em[p*4+:4] | m[3:0];
      note(3, em);
      exec(OP_EXP_IN, p[2:0], 8'h00);
      note(0, {12'h000, expi[p*4+:4]});
    end
    // Registers: wrap at both ends, then indirect access through R0.
    exec(OP_MOV_REG_IMM, 3'h7, 8'hff);
    exec(OP_INC_REG, 3'h7, 8'h00);
    exec(OP_MOV_A_REG, 3'h7, 8'h00);
    note(0, 16'h0000);
    exec(OP_MOV_REG_IMM, 3'h0, 8'h00);
    exec(OP_DEC_REG, 3'h0, 8'h00);
    exec(OP_MOV_A_REG, 3'h0, 8'h00);
    note(0, 16'h00ff);
    exec(OP_MOV_REG_IMM, 3'h0, 8'h20);
    exec(OP_MOV_IND_IMM, 3'h0, 8'h3c);
    exec(OP_INC_IND, 3'h0, 8'h00);
    exec(OP_MOV_A_IND, 3'h0, 8'h00);
    note(0, 16'h003d);
    exec(OP_MOV_A_IMM, 3'h0, 8'h9a);
    exec(OP_DIGIT_XCH, 3'h0, 8'h00);
    note(0, 16'h009d);
    exec(OP_MOV_A_IND, 3'h0, 8'h00);
    note(0, 16'h003a);
    // Bank one has its own R0, so the indirect pointer follows the selected bank.
    exec(OP_BANK_SEL, 3'h1, 8'h00);
    note(5, 16'h0038);
    exec(OP_MOV_REG_IMM, 3'h0, 8'h21);
    exec(OP_MOV_A_IMM, 3'h0, 8'h5e);
    exec(OP_MOV_IND_A, 3'h0, 8'h00);
    exec(OP_BANK_SEL, 3'h0, 8'h00);
    exec(OP_MOV_A_IND, 3'h0, 8'h00);
    note(0, 16'h003a);
    exec(OP_MOV_A_REG, 3'h0, 8'h00);
    note(0, 16'h0020);
    exec(OP_BANK_SEL, 3'h1, 8'h00);
    exec(OP_MOV_A_IND, 3'h0, 8'h00);
    note(0, 16'h005e);
    exec(OP_BANK_SEL, 3'h0, 8'h00);
    // Call into bank one, lookups from there, then both return forms.
    bank = 1'b1;
    page = 3'b101;
    exec(OP_CALL, 3'h0, 8'h12);
    note(7, 16'h0d12);
    note(5, 16'h0029);
    exec(OP_MOV_A_IMM, 3'h0, 8'h47);
    exec(OP_INPAGE_LOOKUP, 3'h0, 8'h00);
    note(0, 16'h009a);
    exec(OP_MOV_A_IMM, 3'h0, 8'h5c);
    exec(OP_PAGE3_LOOKUP, 3'h0, 8'h00);
    note(0, 16'h00e7);
    exec(OP_FLAG_CPL, 3'h1, 8'h00);
    exec(OP_RETURN_RESTORE_STATUS, 3'h0, 8'h00);
    note(5, 16'h0028);
    exec(OP_CALL, 3'h0, 8'h12);
    exec(OP_FLAG_CPL, 3'h1, 8'h00);
    exec(OP_RET, 3'h0, 8'h00);
    note(5, 16'h0008);
    // Program status write and read back, with a carry clear in between.
    exec(OP_MOV_A_IMM, 3'h0, 8'hc5);
    exec(OP_MOV_PSW_A, 3'h0, 8'h00);
    note(5, 16'h00cd);
    exec(OP_FLAG_CLR, 3'h0, 8'h00);
    exec(OP_MOV_A_PSW, 3'h0, 8'h00);
    note(0, 16'h004d);
    // External interrupt: a blocked request never reaches the vector output.
    exec(OP_EXT_IRQ_BLOCK, 3'h0, 8'h00);
    irq_n = 1'b0;
    idle(4);
    note(8, 16'h0000);
    exec(OP_EXT_IRQ_ALLOW, 3'h0, 8'h00);
    note(8, 16'h0001);
    exec(OP_EXT_IRQ_BLOCK, 3'h0, 8'h00);
    note(8, 16'h0000);
    irq_n = 1'b1;
    // Event mode counts T1 falling edges; halt then ignores further edges.
    exec(OP_MOV_A_IMM, 3'h0, 8'h00);
    exec(OP_MOV_T_A, 3'h0, 8'h00);
    exec(OP_CNT_BEGIN, 3'h0, 8'h00);
    for (int e = 0; e < 6; e++)
    begin
      if (e == 3)
        exec(OP_TC_HALT, 3'h0, 8'h00);
      t1 = 1'b0;
      idle(4);
      t1 = 1'b1;
      idle(4);
    end
    exec(OP_MOV_A_T, 3'h0, 8'h00);
    note(0, 16'h0003);
    note(0, 16'h0003);
    // Timer mode: about one count per prescale period, then overflow request.
    exec(OP_TIMER_BEGIN, 3'h0, 8'h00);
    idle(10 * PRE);
    exec(OP_TC_HALT, 3'h0, 8'h00);
    exec(OP_MOV_A_T, 3'h0, 8'h00);
    rng = acc >= 8'd12 && acc <= 8'd16;
    note(11, 16'h0001);
    exec(OP_MOV_A_IMM, 3'h0, 8'hff);
    exec(OP_MOV_T_A, 3'h0, 8'h00);
    exec(OP_TIMER_IRQ_ALLOW, 3'h0, 8'h00);
    exec(OP_TIMER_BEGIN, 3'h0, 8'h00);
    idle(3 * PRE);
    note(9, 16'h0001);
    // Blocking hides the pending overflow without clearing it.
    exec(OP_TIMER_IRQ_BLOCK, 3'h0, 8'h00);
    note(9, 16'h0000);
    exec(OP_TIMER_IRQ_ALLOW, 3'h0, 8'h00);
    note(9, 16'h0001);
    ack = 1'b1;
    idle(1);
    ack = 1'b0;
    idle(2);
    note(9, 16'h0000);
    exec(OP_TC_HALT, 3'h0, 8'h00);
    idle(2);
    finish_test();
  end
endmodule : test_slave_exec_unit
